// [core/chip_select_wait_decoder.v]
// Chip select and wait decoder for the external memory bus.
// Assumes an APB master for configuration and a CPU-side requester
// that holds its request until done pulses; on-chip hit flags
// come from logic on the same clock.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "cs_wait_map.vh"

module chip_select_wait_decoder (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    // CPU request side
    input  wire        cpuReq,
    input  wire        cpuWrite,
    input  wire        cpuWord,
    input  wire [23:0] cpuAddr,
    input  wire [15:0] cpuWdata,
    input  wire        onChipIoHit,
    input  wire        onChipMemHit,
    output reg         cpuDone,
    output reg  [15:0] cpuRdata,
    // External bus
    output reg  [23:0] extAddr,
    output reg  [15:0] extDataOut,
    output reg         extDataOeLo_n,
    output reg         extDataOeHi_n,
    input  wire [15:0] extDataIn,
    output reg         extRd_n,
    output reg         extWrLo_n,
    output reg         extWrHi_n,
    input  wire        extWait_n,
    // Select pins (two-way port pins)
    output reg  [2:0]  selOut,
    output wire [2:0]  selOe_n,
    input  wire [2:0]  selIn
);

    // ----------------------------------------------------------------
    // State codes
    // ----------------------------------------------------------------
    localparam [3:0] S_IDLE   = 4'h1;
    localparam [3:0] S_STROBE = 4'h2;
    localparam [3:0] S_HOLD   = 4'h4;
    localparam [3:0] S_END    = 4'h8;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0]  ioCtrl_q;
    reg  [7:0]  ramCtrl_q;
    reg  [7:0]  romCtrl_q;
    reg  [7:0]  pinMode_q;
    reg  [31:0] prdata_q;
    reg  [3:0]  state_q;
    reg  [2:0]  blk_q;
    reg         bus8_q;
    reg  [1:0]  waitMode_q;
    reg  [1:0]  waitCnt_q;
    reg         phase_q;
    reg         split_q;
    reg         word_q;
    reg         write_q;
    reg  [23:0] base_q;
    reg  [15:0] wdata_q;
    reg  [2:0]  waitSync_q;
    reg         defaultHit_q;
    reg         waitLevel_q;
    reg  [2:0]  selMeta_q;
    reg  [2:0]  selMid_q;
    reg  [2:0]  selLast_q;
    reg  [2:0]  selLevel_q;

    // Select pins drive only once software turns them into outputs
    // Pins start as inputs
    assign selOe_n = ~pinMode_q[2:0];

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function blockHit;
        input [7:0]  ctrl;
        input [23:0] a;
        input [23:0] lowFirst;
        input [23:0] lowLast;
        begin
            if (!ctrl[`F_ENABLE]) begin
                blockHit = 1'b0;
            end else if (ctrl[`F_AREA_HI:`F_AREA_LO] == 2'h0) begin
                blockHit = (a >= lowFirst) && (a <= lowLast);
            end else begin
                blockHit = (a[23:22] == ctrl[`F_AREA_HI:`F_AREA_LO]);
            end
        end
    endfunction

    wire ioHit;
    wire ramHit;
    wire romHit;
    wire onChip;
    reg  [2:0] blkSel;
    reg  [7:0] selCtrl;

    assign ioHit  = blockHit(ioCtrl_q, cpuAddr, `IO_LOW_FIRST, `IO_LOW_LAST);
    assign ramHit = blockHit(ramCtrl_q, cpuAddr, `RAM_LOW_FIRST, `RAM_LOW_LAST);
    assign romHit = blockHit(romCtrl_q, cpuAddr, `ROM_LOW_FIRST, `ROM_LOW_LAST);
    assign onChip = onChipIoHit | onChipMemHit;

    always @* begin
        if (ioHit) begin
            blkSel  = 3'h1;
            selCtrl = ioCtrl_q;
        end else if (ramHit) begin
            blkSel  = 3'h2;
            selCtrl = ramCtrl_q;
        end else if (romHit) begin
            blkSel  = 3'h4;
            selCtrl = romCtrl_q;
        end else begin
            blkSel  = 3'h0;
            selCtrl = {3'h0, 1'b0, `WAIT_NONE, 2'h0};
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    wire       setup;
    wire       access;
    wire       mapped;
    wire [7:0] idx;

    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign idx     = paddr[9:2];
    assign mapped  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                     (idx >= `IDX_IO_CTRL) && (idx <= `IDX_PIN_MODE);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            // Only ROM block on after reset
            ioCtrl_q  <= `RST_IO_CTRL;
            ramCtrl_q <= `RST_RAM_CTRL;
            romCtrl_q <= `RST_ROM_CTRL;
            pinMode_q <= `RST_PIN_MODE;
        end else if (access && pwrite && mapped) begin
            // Control values take effect as written
            case (idx)
                `IDX_IO_CTRL:  ioCtrl_q  <= pwdata[7:0];
                `IDX_RAM_CTRL: ramCtrl_q <= pwdata[7:0];
                // Same field layout for all blocks
                `IDX_ROM_CTRL: romCtrl_q <= pwdata[7:0];
                `IDX_PIN_MODE: pinMode_q <= {5'h00, pwdata[2:0]};
                default:       pinMode_q <= pinMode_q;
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            case (idx)
                `IDX_IO_CTRL:  prdata_q <= {24'h000000, ioCtrl_q};
                `IDX_RAM_CTRL: prdata_q <= {24'h000000, ramCtrl_q};
                `IDX_ROM_CTRL: prdata_q <= {24'h000000, romCtrl_q};
                `IDX_STATUS:   prdata_q <= {24'h000000, defaultHit_q, state_q == S_IDLE,
                                            ~selLevel_q, ~selOut};
                `IDX_PIN_MODE: prdata_q <= {24'h000000, pinMode_q};
                default:       prdata_q <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire waitLow;

    // A level counts once stages two and three agree;
    // select pins start at their pull levels
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            waitSync_q  <= 3'h7;
            waitLevel_q <= 1'b1;
            selMeta_q   <= 3'h3;
            selMid_q    <= 3'h3;
            selLast_q   <= 3'h3;
            selLevel_q  <= 3'h3;
        end else begin
            waitSync_q <= {waitSync_q[1:0], extWait_n};
            if (waitSync_q[1] == waitSync_q[2]) begin
                waitLevel_q <= waitSync_q[2];
            end
            selMeta_q  <= selIn;
            selMid_q   <= selMeta_q;
            selLast_q  <= selMid_q;
            selLevel_q <= (selMid_q & selLast_q) | (selLevel_q & (selMid_q | selLast_q));
        end
    end

    assign waitLow = ~waitLevel_q;

    // ----------------------------------------------------------------
    // Lane planning
    // ----------------------------------------------------------------
    wire [23:0] curAddr;
    wire        laneHi;
    wire        bothLanes;
    wire [7:0]  outByte;
    wire [7:0]  inByte;

    assign curAddr   = base_q + {23'h000000, phase_q};
    assign bothLanes = ~bus8_q & word_q & ~base_q[0];
    assign laneHi    = ~bus8_q & curAddr[0];
    assign outByte   = phase_q ? wdata_q[15:8] : wdata_q[7:0];
    // Only the active lane is read
    assign inByte    = laneHi ? extDataIn[15:8] : extDataIn[7:0];

    // ----------------------------------------------------------------
    // Bus cycle sequencer
    // ----------------------------------------------------------------
    reg [1:0] waitsFor;

    always @* begin
        case (waitMode_q)
            `WAIT_TWO:  waitsFor = 2'h2;
            `WAIT_ONE:  waitsFor = 2'h1;
            `WAIT_EXT:  waitsFor = 2'h1;
            default:    waitsFor = 2'h0;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q       <= S_IDLE;
            blk_q         <= 3'h0;
            bus8_q        <= 1'b0;
            waitMode_q    <= `WAIT_NONE;
            waitCnt_q     <= 2'h0;
            phase_q       <= 1'b0;
            split_q       <= 1'b0;
            word_q        <= 1'b0;
            write_q       <= 1'b0;
            base_q        <= 24'h000000;
            wdata_q       <= 16'h0000;
            defaultHit_q  <= 1'b0;
            cpuDone       <= 1'b0;
            cpuRdata      <= 16'h0000;
            extAddr       <= 24'h000000;
            extDataOut    <= 16'h0000;
            extDataOeLo_n <= 1'b1;
            extDataOeHi_n <= 1'b1;
            extRd_n       <= 1'b1;
            extWrLo_n     <= 1'b1;
            extWrHi_n     <= 1'b1;
            selOut        <= 3'h7;
        end else begin
            cpuDone <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    // Requests hitting on-chip units are not served
                    if (cpuReq && !onChip && !cpuDone) begin
                        // Boot fetch decodes into the ROM block
                        blk_q        <= blkSel;
                        bus8_q       <= selCtrl[`F_BUS8];
                        waitMode_q   <= selCtrl[`F_WAIT_HI:`F_WAIT_LO];
                        defaultHit_q <= (blkSel == 3'h0);
                        word_q       <= cpuWord;
                        write_q      <= cpuWrite;
                        base_q       <= cpuAddr;
                        wdata_q      <= cpuWdata;
                        split_q      <= cpuWord & (selCtrl[`F_BUS8] | cpuAddr[0]);
                        phase_q      <= 1'b0;
                        state_q      <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    // Select held low from strobe to end
                    selOut    <= ~blk_q;
                    extAddr   <= curAddr;
                    waitCnt_q <= 2'h0;
                    state_q   <= S_HOLD;
                    if (write_q) begin
                        extDataOut    <= bothLanes ? wdata_q : {outByte, outByte};
                        extDataOeLo_n <= ~(bothLanes | ~laneHi);
                        extDataOeHi_n <= ~(bothLanes | laneHi);
                        extWrLo_n     <= ~(bothLanes | ~laneHi);
                        extWrHi_n     <= ~(bothLanes | laneHi);
                    end else begin
                        extRd_n <= 1'b0;
                    end
                end
                S_HOLD: begin
                    if (waitCnt_q < waitsFor) begin
                        waitCnt_q <= waitCnt_q + 2'h1;
                    end else if (!(waitMode_q == `WAIT_EXT && waitLow)) begin
                        state_q <= S_END;
                    end
                end
                S_END: begin
                    if (!write_q) begin
                        if (bothLanes) begin
                            cpuRdata <= extDataIn;
                        end else if (phase_q) begin
                            cpuRdata[15:8] <= inByte;
                        end else begin
                            cpuRdata[7:0] <= inByte;
                        end
                    end
                    selOut        <= 3'h7;
                    extRd_n       <= 1'b1;
                    extWrLo_n     <= 1'b1;
                    extWrHi_n     <= 1'b1;
                    extDataOeLo_n <= 1'b1;
                    extDataOeHi_n <= 1'b1;
                    if (split_q && !phase_q) begin
                        phase_q <= 1'b1;
                        state_q <= S_STROBE;
                    end else begin
                        cpuDone <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule // chip_select_wait_decoder

// [core/cs_wait_map.vh]
// Constants of the chip select and wait decoder: register indexes,
// field positions, reset values and decode limits.
// Assumes inclusion by the decoder module only.
`ifndef CS_WAIT_MAP_VH
`define CS_WAIT_MAP_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_IO_CTRL   8'h68
`define IDX_RAM_CTRL  8'h69
`define IDX_ROM_CTRL  8'h6a
`define IDX_STATUS    8'h6b
`define IDX_PIN_MODE  8'h6c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define F_ENABLE  7
`define F_SYSTEM  6
`define F_CAS     5
`define F_BUS8    4
`define F_WAIT_HI 3
`define F_WAIT_LO 2
`define F_AREA_HI 1
`define F_AREA_LO 0

`define WAIT_TWO  2'h0
`define WAIT_ONE  2'h1
`define WAIT_EXT  2'h2
`define WAIT_NONE 2'h3

`define RST_IO_CTRL  8'h00
`define RST_RAM_CTRL 8'h00
`define RST_ROM_CTRL 8'h80
`define RST_PIN_MODE 8'h00

// ----------------------------------------------------------------
// Decode limits
// ----------------------------------------------------------------
`define IO_LOW_FIRST  24'h007f00
`define IO_LOW_LAST   24'h007fff
`define RAM_LOW_FIRST 24'h000480
`define RAM_LOW_LAST  24'h007fff
`define ROM_LOW_FIRST 24'h008000
`define ROM_LOW_LAST  24'h3fffff

`endif

// [verif/cs_wait_checker.sv]
// Checker: select, strobe and lane relations of the external bus.
// Assumes a bind onto chip_select_wait_decoder.
`timescale 1ns/1ps
module cs_wait_checker (
    // Clock and reset
    input wire       clk,
    input wire       rst,
    // Watched outputs
    input wire       cpuDone,
    input wire       extDataOeLo_n,
    input wire       extDataOeHi_n,
    input wire       extRd_n,
    input wire       extWrLo_n,
    input wire       extWrHi_n,
    input wire [2:0] selOut,
    input wire [2:0] selOe_n
);
    wire idle = extRd_n & extWrLo_n & extWrHi_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_lane_lo; extDataOeLo_n |-> extWrLo_n; endproperty
    a_lane_lo: assert property (p_lane_lo) else $error("low strobe on idle lane");
    property p_lane_hi; extDataOeHi_n |-> extWrHi_n; endproperty
    a_lane_hi: assert property (p_lane_hi) else $error("high strobe on idle lane");
    property p_free_hi; !extWrLo_n && extWrHi_n |-> extDataOeHi_n; endproperty
    a_free_hi: assert property (p_free_hi) else $error("unused high lane driven");
    property p_free_lo; !extWrHi_n && extWrLo_n |-> extDataOeLo_n; endproperty
    a_free_lo: assert property (p_free_lo) else $error("unused low lane driven");
    property p_read_lanes; !extRd_n |-> extDataOeLo_n && extDataOeHi_n; endproperty
    a_read_lanes: assert property (p_read_lanes) else $error("lane driven in read");
    property p_one_sel; $onehot0(~selOut); endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    property p_reset_pins;
        @(posedge clk) disable iff (1'b0)
            rst && $past(rst) |-> selOe_n == 3'b111 && selOut == 3'b111;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pin driven in reset");
    property p_sel_strobe; (selOut != 3'b111) |-> !idle; endproperty
    a_sel_strobe: assert property (p_sel_strobe) else $error("select without strobe");
    property p_done_after; cpuDone |-> !$past(idle) || !$past(idle, 2); endproperty
    a_done_after: assert property (p_done_after) else $error("done without cycle");
    property p_done_pulse; cpuDone |=> !cpuDone; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_rd_len; $fell(extRd_n) |-> !extRd_n [*2]; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe too short");
endmodule // cs_wait_checker

// [verif/ext_memory_model.sv]
// External memories behind the three selects and the default area.
// Assumes narrow[i] marks block i as an 8-bit device on the low lane.
`timescale 1ns/1ps
module ext_memory_model (
    // Clock
    input  wire         clk,
    // External bus
    input  wire  [23:0] extAddr,
    input  wire  [15:0] extDataOut,
    input  wire         extRd_n,
    input  wire         extWrLo_n,
    input  wire         extWrHi_n,
    input  wire  [2:0]  selOut,
    input  wire  [2:0]  narrow,
    output logic [15:0] extDataIn
);
    logic [7:0] mem [int];
    wire        bus8 = |(narrow & ~selOut);
    initial extDataIn = 16'h0;
    function automatic logic [7:0] rd(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5a;
    endfunction
    // Idle bus or the high lane of an 8-bit device shows a changing pattern
    always @(posedge clk) begin
        if (!extRd_n && bus8)
            extDataIn <= {~extDataIn[15:8], rd(extAddr)};
        else if (!extRd_n)
            extDataIn <= {rd(extAddr | 24'h1), rd(extAddr & 24'hfffffe)};
        else
            extDataIn <= ~extDataIn;
        if (!extWrLo_n)
            mem[bus8 ? extAddr : extAddr & 24'hfffffe] = extDataOut[7:0];
        if (!extWrHi_n)
            mem[extAddr | 24'h1] = extDataOut[15:8];
    end
endmodule // ext_memory_model

// [verif/tb.sv]
// Testbench: APB setup, CPU accesses, select pins and refusals.
// Assumes the memory model on the bus and the checker bound below.
`timescale 1ns/1ps
module tb;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, note;
    logic        cpuReq = 0, cpuWrite = 0, cpuWord = 0, ioHit = 0, memHit = 0;
    logic [23:0] cpuAddr = 0;
    logic [15:0] cpuWdata = 0;
    logic [2:0]  narrow = 0;
    logic        waitN = 1;
    wire         pready, pslverr, cpuDone, oeLo_n, oeHi_n, rd_n, wrLo_n, wrHi_n;
    wire  [31:0] prdata;
    wire  [15:0] cpuRdata, extDataOut, extDataIn;
    wire  [23:0] extAddr;
    wire  [2:0]  selOut, selOe_n, selPin;
    logic [31:0] expQ [$];
    logic [7:0]  shadow [int];
    int          mismatches = 0, samples_checked = 0;
    // pulls: high on io and ram pins, low on rom pin
    assign selPin = {~selOe_n[2] & selOut[2], selOe_n[1] | selOut[1], selOe_n[0] | selOut[0]};
    chip_select_wait_decoder u_chip_select_wait_decoder (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
        .cpuWord(cpuWord), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .onChipIoHit(ioHit),
        .onChipMemHit(memHit), .cpuDone(cpuDone), .cpuRdata(cpuRdata), .extAddr(extAddr),
        .extDataOut(extDataOut), .extDataOeLo_n(oeLo_n), .extDataOeHi_n(oeHi_n),
        .extDataIn(extDataIn), .extRd_n(rd_n), .extWrLo_n(wrLo_n), .extWrHi_n(wrHi_n),
        .extWait_n(waitN), .selOut(selOut), .selOe_n(selOe_n), .selIn(selPin));
    ext_memory_model u_ext_memory_model (.clk(clk), .extAddr(extAddr),
        .extDataOut(extDataOut), .extRd_n(rd_n), .extWrLo_n(wrLo_n), .extWrHi_n(wrHi_n),
        .selOut(selOut), .narrow(narrow), .extDataIn(extDataIn));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [7:0] memByte(input logic [23:0] a);
        return shadow.exists(a) ? shadow[a] : a[7:0] ^ 8'h5a;
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin mismatches++; print_verdict(); end
        q = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Expected read data is noted for the monitor; lat 0 skips the timing compare
    task automatic acc(input logic wr, input logic wd, input logic [23:0] a,
                       input logic [2:0] sel, input int lat);
        logic [15:0] d;
        logic [2:0]  seen;
        int          n;
        d = 16'($urandom);
        seen = 0;
        if (wr) begin
            shadow[a] = d[7:0];
            if (wd) shadow[a + 1] = d[15:8];
        end else expQ.push_back({wd ? 16'hffff : 16'h00ff, memByte(a + 1), memByte(a)});
        @(posedge clk);
        cpuReq <= 1; cpuWrite <= wr; cpuWord <= wd; cpuAddr <= a; cpuWdata <= d;
        for (n = 1; n < 40; n++) begin
            @(posedge clk);
            #1 seen |= ~selOut;
            if (cpuDone === 1'b1) break;
        end
        if (n == 40) begin mismatches++; print_verdict(); end
        @(posedge clk) cpuReq <= 0;
        check(seen, sel);
        if (lat > 0) check(n, lat);
    endtask
    always @(negedge clk) begin
        if (cpuDone === 1'b1 && cpuWrite === 1'b0 && expQ.size() > 0) begin
            note = expQ.pop_front();
            check(cpuRdata & note[31:16], note[15:0] & note[31:16]);
        end
    end
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        logic [31:0] q;
        logic        err;
        int          i;
        void'($urandom(32'hb292));
        repeat (5) @(posedge clk);
        rst <= 0;
        check(selOe_n, 3'b111);
        apb(0, 12'h1ac, 0, q, err);
        check(q[5:3], 3'b100);
        apb(0, 12'h1a8, 0, q, err);
        check(q, 32'h80);
        apb(0, 12'h1a0, 0, q, err);
        check(q, 32'h00);
        acc(0, 1, 24'h008000, 3'b100, 6);
        acc(0, 1, 24'h007f10, 3'b000, 4);
        // 8-bit boot memory: only the low lane carries code bytes
        narrow <= 3'b100;
        acc(0, 0, 24'h008000, 3'b100, 6);
        acc(0, 0, 24'h008002, 3'b100, 6);
        acc(0, 0, 24'h008004, 3'b100, 6);
        // distinct regions apart from the documented io overlap
        apb(1, 12'h1a0, 32'h90, q, err);
        apb(1, 12'h1a4, 32'h9c, q, err);
        apb(1, 12'h1a8, 32'h84, q, err);
        apb(1, 12'h1b0, 32'h07, q, err);
        @(negedge clk);
        check(selOe_n, 3'b000);
        apb(1, 12'h3fc, 32'h05, q, err);
        check(err, 1'b1);
        narrow <= 3'b011;
        acc(0, 0, 24'h007f00, 3'b001, 6);
        acc(0, 0, 24'h007fff, 3'b001, 6);
        acc(0, 1, 24'h007f21, 3'b001, 11);
        acc(0, 0, 24'h000480, 3'b010, 4);
        acc(0, 0, 24'h00047f, 3'b000, 4);
        acc(0, 0, 24'h007eff, 3'b010, 4);
        acc(0, 1, 24'h008000, 3'b100, 5);
        acc(0, 0, 24'h3fffff, 3'b100, 5);
        acc(0, 0, 24'h400000, 3'b000, 4);
        acc(1, 0, 24'h000501, 3'b010, 4);
        acc(1, 1, 24'h009001, 3'b100, 9);
        acc(1, 0, 24'h009004, 3'b100, 5);
        acc(0, 1, 24'h000500, 3'b010, 7);
        acc(0, 1, 24'h009000, 3'b100, 5);
        acc(0, 1, 24'h009004, 3'b100, 5);
        // Wait mode 10: the held wait pin stretches the cycle
        apb(1, 12'h1a8, 32'h88, q, err);
        waitN <= 0;
        fork
            acc(0, 0, 24'h009002, 3'b100, 13);
            begin
                repeat (8) @(posedge clk);
                waitN <= 1;
            end
        join
        for (i = 1; i < 4; i++) begin
            apb(1, 12'h1a4, 32'h9c | i, q, err);
            acc(0, 0, {i[1:0], 22'h000010}, 3'b010, 4);
        end
        acc(0, 0, 24'h000480, 3'b000, 4);
        // On-chip hits are never passed to the external bus
        for (i = 0; i < 2; i++) begin
            err = 0;
            @(posedge clk);
            ioHit <= (i == 0); memHit <= (i == 1); cpuReq <= 1; cpuWrite <= 0;
            repeat (12) begin
                @(negedge clk);
                err |= (cpuDone !== 1'b0);
            end
            @(posedge clk);
            cpuReq <= 0; ioHit <= 0; memHit <= 0;
            check(err, 1'b0);
        end
        print_verdict();
    end
endmodule // tb
bind chip_select_wait_decoder cs_wait_checker u_cs_wait_checker (.clk(clk), .rst(rst),
    .cpuDone(cpuDone), .extDataOeLo_n(extDataOeLo_n), .extDataOeHi_n(extDataOeHi_n),
    .extRd_n(extRd_n), .extWrLo_n(extWrLo_n), .extWrHi_n(extWrHi_n), .selOut(selOut),
    .selOe_n(selOe_n));
